// >>> hdl/uart_frame_check_addr_match.sv
// serial port: four modes, stop-bit check, multidrop address recognition
// assumes a single-cycle register port master on clk and raw pins on rxd/txd
//
// Design decisions made here: strobed register access and the register offsets.
`include "uart_aar_params.svh"

// Notes on behaviour
// - any buffer write loads transmitter and starts a frame in every mode
// - buffer read returns the received byte, never the transmit data
// - two mode bits in the control register select one of four modes
// - mode 0 receive starts when receive flag clear, receive enabled and transmitter idle
// - other modes start receiving on a start bit, only when receive enabled
// - with frame check selected, missing stop bit in modes 1-3 sets error flag
// - error flag stays set until software clears it; good frames leave it
// - with frame check selected, modes 1-3 raise receive flag at stop bit, not last data
// - 9-bit modes with filter on: flag only for ninth bit 1 and address hit
// - filter off: frames with ninth bit 0 are received normally
// - mode 1 with filter: stop bit acts as ninth bit, needs hit and stop
// - in mode 0 the filter bit changes nothing
// - given address compares own bit where mask is 1, ignores where 0
// - broadcast is own OR mask; its zero bits are ignored
// - reset clears own address and mask, so every address matches
module uart_frame_check_addr_match
  import uart_aar_pkg::*;
#(
  parameter int BIT_CYC_VAR  = `UART_BIT_CYC_VAR,
  parameter int BIT_CYC_FIX  = `UART_BIT_CYC_FIX,
  parameter int HALF_CYC_M0  = `UART_HALF_CYC_M0
)(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire uart_aar_pkg::bus_req_s bus_req,
  output logic [7:0]                 rd_data,
  output logic                       irq,
  input  wire logic                  rxd_in,
  output logic                       rxd_out,
  output logic                       rxd_oe,
  output logic                       txd_out
);
  import uart_aar_pkg::*;

  localparam uart_state_s STATE_RST = '{own: `UART_RST_ADDR, mask: `UART_RST_MASK, rx_state: RX_IDLE,
                                        txd: 1'b1, rxd_o: 1'b1, sclk: 1'b1, sync1: 1'b1, sync2: 1'b1,
                                        sync3: 1'b1, default: '0};
  localparam logic [15:0] M0_HALF = 16'(HALF_CYC_M0 - 1);

  uart_state_s state_reg;
  uart_state_s state_next;
  logic [15:0] bit_len;
  logic        late;
  logic        tx_evt;
  logic        rx_eval;
  logic        fe_set;
  logic        rx_load;
  logic [8:0]  sh;
  logic [7:0]  byte_v;
  logic        b9_v;
  logic        stop_v;
  logic        given_hit;
  logic        bcast_hit;
  logic        accept;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ========================================================================
  // next state
  always_comb
  begin
    state_next = state_reg;
    tx_evt     = 1'b0;
    rx_eval    = 1'b0;
    fe_set     = 1'b0;
    sh         = state_reg.rx_shift;
    stop_v     = 1'b1;
    // mode 2 runs at the fixed rate, modes 1 and 3 at the variable rate
    bit_len    = (state_reg.mode == 2'b10) ? 16'(BIT_CYC_FIX - 1) : 16'(BIT_CYC_VAR - 1);
    late       = state_reg.fcs || (state_reg.mode == 2'b01 && state_reg.mp_en);

    state_next.sync1 = rxd_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;

    // ======================================================================
    // transmitter
    if (state_reg.tx_busy)
    begin
      if (state_reg.tx_tick != 16'h0000)
        state_next.tx_tick = state_reg.tx_tick - 16'h0001;
      else if (state_reg.mode == 2'b00)
      begin
        state_next.tx_tick = M0_HALF;
        state_next.sclk    = ~state_reg.sclk;
        if (state_reg.sclk)
        begin
          state_next.tx_shift = {1'b1, state_reg.tx_shift[10:1]};
          state_next.rxd_o    = state_reg.tx_shift[1];
          state_next.tx_bits  = state_reg.tx_bits + 4'h1;
          if (state_reg.tx_bits == 4'h7)
          begin
            state_next.tx_busy = 1'b0;
            state_next.rxd_oe  = 1'b0;
            state_next.rxd_o   = 1'b1;
            state_next.sclk    = 1'b1;
            tx_evt             = 1'b1;
          end
        end
      end
      else
      begin
        state_next.tx_tick  = bit_len;
        state_next.tx_shift = {1'b1, state_reg.tx_shift[10:1]};
        state_next.txd      = state_reg.tx_shift[1];
        state_next.tx_bits  = state_reg.tx_bits + 4'h1;
        if (state_reg.tx_bits == ((state_reg.mode == 2'b01) ? 4'h9 : 4'ha))
        begin
          state_next.tx_busy = 1'b0;
          state_next.txd     = 1'b1;
          tx_evt             = 1'b1;
        end
      end
    end

    // ======================================================================
    // receiver
    case (state_reg.rx_state)
      RX_IDLE:
      begin
        if (state_reg.rx_en)
        begin
          if (state_reg.mode == 2'b00)
          begin
            if (!state_reg.rx_done && !state_reg.tx_busy)
            begin
              state_next.rx_state = RX_SHIFT0;
              state_next.sclk     = 1'b0;
              state_next.rx_tick  = M0_HALF;
              state_next.rx_bits  = 4'h0;
            end
          end
          else if (!state_reg.sync2 && state_reg.sync3)
          begin
            state_next.rx_state = RX_START;
            state_next.rx_tick  = {1'b0, bit_len[15:1]};
          end
        end
      end
      RX_START:
      begin
        if (state_reg.rx_tick != 16'h0000)
          state_next.rx_tick = state_reg.rx_tick - 16'h0001;
        else if (!state_reg.sync2)
        begin
          state_next.rx_state = RX_DATA;
          state_next.rx_tick  = bit_len;
          state_next.rx_bits  = 4'h0;
        end
        else
          state_next.rx_state = RX_IDLE; // glitch, not a start bit
      end
      RX_DATA:
      begin
        if (state_reg.rx_tick != 16'h0000)
          state_next.rx_tick = state_reg.rx_tick - 16'h0001;
        else
        begin
          sh                  = {state_reg.sync2, state_reg.rx_shift[8:1]};
          state_next.rx_shift = sh;
          state_next.rx_bits  = state_reg.rx_bits + 4'h1;
          state_next.rx_tick  = bit_len;
          if (state_reg.rx_bits == ((state_reg.mode == 2'b01) ? 4'h7 : 4'h8))
          begin
            state_next.rx_state = RX_STOP;
            rx_eval             = !late;
          end
        end
      end
      RX_STOP:
      begin
        if (state_reg.rx_tick != 16'h0000)
          state_next.rx_tick = state_reg.rx_tick - 16'h0001;
        else
        begin
          state_next.rx_state = RX_IDLE;
          stop_v              = state_reg.sync2;
          fe_set              = state_reg.fcs && !state_reg.sync2;
          rx_eval             = late;
        end
      end
      RX_SHIFT0:
      begin
        if (state_reg.rx_tick != 16'h0000)
          state_next.rx_tick = state_reg.rx_tick - 16'h0001;
        else
        begin
          state_next.rx_tick = M0_HALF;
          state_next.sclk    = ~state_reg.sclk;
          if (!state_reg.sclk)
          begin
            sh                  = {state_reg.sync2, state_reg.rx_shift[8:1]};
            state_next.rx_shift = sh;
            state_next.rx_bits  = state_reg.rx_bits + 4'h1;
            if (state_reg.rx_bits == 4'h7)
            begin
              state_next.rx_state = RX_IDLE;
              rx_eval             = 1'b1;
            end
          end
        end
      end
      default:
        state_next.rx_state = RX_IDLE;
    endcase

    // ======================================================================
    // address filter; mode 1 and 0 hold the byte one place higher
    byte_v    = (state_reg.mode[1] == 1'b0) ? sh[8:1] : sh[7:0];
    b9_v      = sh[8];
    given_hit = ((byte_v ^ state_reg.own) & state_reg.mask) == 8'h00;
    bcast_hit = ((~byte_v) & (state_reg.own | state_reg.mask)) == 8'h00;
    case (state_reg.mode)
      2'b00:   accept = 1'b1;
      2'b01:   accept = !state_reg.mp_en || ((given_hit || bcast_hit) && stop_v);
      default: accept = !state_reg.mp_en || (b9_v && (given_hit || bcast_hit));
    endcase
    // an unread byte is kept; a newer one is dropped rather than overwrite it
    rx_load = rx_eval && accept && !state_reg.rx_done;

    // ======================================================================
    // register writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        `UART_OFS_BUFFER:
        begin
          state_next.tx_busy = 1'b1;
          state_next.tx_bits = 4'h0;
          if (state_reg.mode == 2'b00)
          begin
            state_next.tx_shift = {3'b111, bus_req.wdata};
            state_next.rxd_o    = bus_req.wdata[0];
            state_next.rxd_oe   = 1'b1;
            state_next.sclk     = 1'b0;
            state_next.tx_tick  = M0_HALF;
            state_next.rx_state = RX_IDLE; // shared pin: sending wins
          end
          else
          begin
            state_next.tx_shift = {1'b1, (state_reg.mode == 2'b01) ? 1'b1 : state_reg.tx_b9, bus_req.wdata, 1'b0};
            state_next.txd      = 1'b0;
            state_next.tx_tick  = bit_len;
          end
        end
        `UART_OFS_CONTROL:
        begin
          state_next.mode    = {bus_req.wdata[`UART_CTL_MODE_HI], bus_req.wdata[`UART_CTL_MODE_LO]};
          state_next.mp_en   = bus_req.wdata[`UART_CTL_MP_EN];
          state_next.rx_en   = bus_req.wdata[`UART_CTL_RX_EN];
          state_next.tx_b9   = bus_req.wdata[`UART_CTL_TX_B9];
          state_next.tx_done = state_reg.tx_done && bus_req.wdata[`UART_CTL_TX_DONE];
          state_next.rx_done = state_reg.rx_done && bus_req.wdata[`UART_CTL_RX_DONE];
        end
        `UART_OFS_POWER:
        begin
          state_next.fcs = bus_req.wdata[`UART_PWR_FCS];
          state_next.fe  = state_reg.fe && bus_req.wdata[`UART_PWR_FE];
        end
        `UART_OFS_OWN:      state_next.own   = bus_req.wdata;
        `UART_OFS_MASK:     state_next.mask  = bus_req.wdata;
        `UART_OFS_IRQ_MASK: state_next.imask = bus_req.wdata[2:0];
        default:            state_next.imask = state_reg.imask;
      endcase
    end

    // ======================================================================
    // register reads; data stands one cycle, zero otherwise
    state_next.rdata = 8'h00;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `UART_OFS_BUFFER:   state_next.rdata = state_reg.rbuf;
        `UART_OFS_CONTROL:  state_next.rdata = {state_reg.mode, state_reg.mp_en, state_reg.rx_en, state_reg.tx_b9,
                                                state_reg.rx_b9, state_reg.tx_done, state_reg.rx_done};
        `UART_OFS_POWER:    state_next.rdata = {state_reg.fe, state_reg.fcs, 6'h00};
        `UART_OFS_OWN:      state_next.rdata = state_reg.own;
        `UART_OFS_MASK:     state_next.rdata = state_reg.mask;
        `UART_OFS_IRQ_STAT:
        begin
          state_next.rdata = {5'h00, state_reg.ist};
          state_next.ist   = 3'h0;
        end
        `UART_OFS_IRQ_MASK: state_next.rdata = {5'h00, state_reg.imask};
        default:            state_next.rdata = 8'h00;
      endcase
    end

    // ======================================================================
    // hardware sets last, so they win over a clear in the same cycle
    if (tx_evt)
    begin
      state_next.tx_done            = 1'b1;
      state_next.ist[`UART_IRQ_TX]  = 1'b1;
    end
    if (rx_load)
    begin
      state_next.rbuf               = byte_v;
      state_next.rx_b9              = (state_reg.mode == 2'b01) ? stop_v : b9_v;
      state_next.rx_done            = 1'b1;
      state_next.ist[`UART_IRQ_RX]  = 1'b1;
    end
    if (fe_set && state_reg.mode != 2'b00)
    begin
      state_next.fe                 = 1'b1;
      state_next.ist[`UART_IRQ_FE]  = 1'b1;
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= STATE_RST;
    else
      state_reg <= state_next;
  end

  assign rd_data = state_reg.rdata;
  assign irq     = |(state_reg.ist & state_reg.imask);
  assign rxd_out = state_reg.rxd_o;
  assign rxd_oe  = state_reg.rxd_oe;
  assign txd_out = (state_reg.mode == 2'b00) ? state_reg.sclk : state_reg.txd;

  // ========================================================================
  // checks
  buf_write_starts_a : assert property (
    (bus_req.wr && bus_req.addr == `UART_OFS_BUFFER) |=> state_reg.tx_busy && state_reg.tx_bits == 4'h0)
    else $error("buffer write did not start a frame");

  buf_read_rx_a : assert property (
    (bus_req.rd && bus_req.addr == `UART_OFS_BUFFER) |=> rd_data == $past(state_reg.rbuf))
    else $error("buffer read did not return received byte");

  mode_bits_a : assert property (
    (bus_req.wr && bus_req.addr == `UART_OFS_CONTROL) |=> state_reg.mode == $past(bus_req.wdata[7:6]))
    else $error("mode bits not taken from control write");

  m0_rx_start_a : assert property (
    (state_reg.rx_state == RX_IDLE && state_reg.mode == 2'b00 && state_reg.rx_en && !state_reg.rx_done
     && !state_reg.tx_busy && !bus_req.wr) |=> state_reg.rx_state == RX_SHIFT0)
    else $error("mode 0 reception did not begin");

  rx_enable_gate_a : assert property (
    (state_reg.rx_state == RX_IDLE && !state_reg.rx_en) |=> state_reg.rx_state == RX_IDLE)
    else $error("reception began while disabled");

  stop_missing_a : assert property (
    (state_reg.rx_state == RX_STOP && state_reg.rx_tick == 16'h0000 && state_reg.fcs && !state_reg.sync2
     && state_reg.mode != 2'b00)
    |=> state_reg.fe && state_reg.ist[`UART_IRQ_FE])
    else $error("missing stop bit not flagged");

  fe_sticky_a : assert property (
    (state_reg.fe && !(bus_req.wr && bus_req.addr == `UART_OFS_POWER)) |=> state_reg.fe)
    else $error("frame error flag dropped by itself");

  flag_at_stop_a : assert property (
    ($rose(state_reg.rx_done) && $past(state_reg.fcs) && $past(state_reg.mode) != 2'b00)
    |-> $past(state_reg.rx_state) == RX_STOP)
    else $error("receive flag not raised at stop bit");

  filter_ninth_a : assert property (
    ($rose(state_reg.rx_done) && $past(state_reg.mode[1]) && $past(state_reg.mp_en)) |-> state_reg.rx_b9)
    else $error("filtered frame accepted with ninth bit 0");

  rx_flag_hold_a : assert property (
    (state_reg.rx_done && !(bus_req.wr && bus_req.addr == `UART_OFS_CONTROL)) |=> state_reg.rx_done)
    else $error("receive flag cleared by hardware");

endmodule : uart_frame_check_addr_match

// >>> pkg/uart_aar_params.svh
// constants for the serial port with frame check and address match
// assumes a 10 MHz system clock; included by the package and the design
`ifndef UART_AAR_PARAMS_SVH
`define UART_AAR_PARAMS_SVH

// ==========================================================================
// timing
`define UART_CLK_HZ        10000000
`define UART_BAUD_VAR      9600
`define UART_BAUD_FIX      312500
`define UART_SHIFT_HZ      833333
`define UART_BIT_CYC_VAR   (`UART_CLK_HZ / `UART_BAUD_VAR)
`define UART_BIT_CYC_FIX   (`UART_CLK_HZ / `UART_BAUD_FIX)
`define UART_HALF_CYC_M0   (`UART_CLK_HZ / (2 * `UART_SHIFT_HZ))

// ==========================================================================
// register offsets
`define UART_OFS_BUFFER    3'h0
`define UART_OFS_CONTROL   3'h1
`define UART_OFS_POWER     3'h2
`define UART_OFS_OWN       3'h3
`define UART_OFS_MASK      3'h4
`define UART_OFS_IRQ_STAT  3'h5
`define UART_OFS_IRQ_MASK  3'h6

// ==========================================================================
// serial_control fields
`define UART_CTL_MODE_HI   7
`define UART_CTL_MODE_LO   6
`define UART_CTL_MP_EN     5
`define UART_CTL_RX_EN     4
`define UART_CTL_TX_B9     3
`define UART_CTL_RX_B9     2
`define UART_CTL_TX_DONE   1
`define UART_CTL_RX_DONE   0

// power_control fields
`define UART_PWR_FE        7
`define UART_PWR_FCS       6

// interrupt status / mask fields
`define UART_IRQ_RX        0
`define UART_IRQ_TX        1
`define UART_IRQ_FE        2

// ==========================================================================
// reset values
`define UART_RST_ADDR      8'h00
`define UART_RST_MASK      8'h00

`endif

// >>> pkg/uart_aar_pkg.sv
// types shared by the serial port and whoever drives its register port
// assumes the constants header sits beside it
`include "uart_aar_params.svh"

package uart_aar_pkg;

  // ========================================================================
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  // ========================================================================
  // receiver states
  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP,
    RX_SHIFT0
  } rx_state_e;

  // ========================================================================
  // whole state of the port
  typedef struct packed {
    logic [1:0]  mode;
    logic        mp_en;
    logic        rx_en;
    logic        tx_b9;
    logic        rx_b9;
    logic        tx_done;
    logic        rx_done;
    logic        fcs;
    logic        fe;
    logic [7:0]  own;
    logic [7:0]  mask;
    logic [2:0]  ist;
    logic [2:0]  imask;
    logic [7:0]  rdata;
    logic [7:0]  rbuf;
    logic        tx_busy;
    logic [10:0] tx_shift;
    logic [3:0]  tx_bits;
    logic [15:0] tx_tick;
    logic        sclk;
    logic        txd;
    logic        rxd_o;
    logic        rxd_oe;
    rx_state_e   rx_state;
    logic [8:0]  rx_shift;
    logic [3:0]  rx_bits;
    logic [15:0] rx_tick;
    logic        sync1;
    logic        sync2;
    logic        sync3;
  } uart_state_s;

endpackage : uart_aar_pkg

// >>> tb/serial_node.sv
// model of a far serial node that sends frames onto the receive pin
// assumes the bench calls send() and the design samples the pin on clk
module serial_node (
  input  wire logic clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // idle line rests high, as with a pull-up
  initial line = 1'b1;

  // ==========================================================================
  // a missing stop bit is sent only when the bench asks for it
  task automatic send(
    input logic [7:0] d,
    input logic       nine,
    input logic       has9,
    input logic       stop,
    input int         cyc
  );
    logic [10:0] f;
    int          n;
    f = has9 ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = has9 ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      line <= f[i];
      repeat (cyc - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
    repeat (2 * cyc) @(posedge clk);
  endtask : send
endmodule : serial_node

// >>> tb/uart_frame_check_addr_match_tb.sv
// bench for the serial port: random and corner frames from the node model
// assumes short bit times set through the design parameters
module uart_frame_check_addr_match_tb;
  import uart_aar_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BC = 8;

  logic       clk;
  logic       reset_n;
  bus_req_s   bus_req;
  logic [7:0] rd_data;
  logic       irq;
  logic       rxd_in;
  logic       rxd_out;
  logic       rxd_oe;
  logic       txd_out;
  int         bad_count;
  int         samples_checked;
  int         cycles;
  int         seed = 86;
  logic [7:0] v;
  logic [7:0] b;
  logic [9:0] f;
  logic [7:0] picks [4] = '{8'hf0, 8'hf5, 8'hf2, 8'hff};

  uart_frame_check_addr_match #(.BIT_CYC_VAR(BC), .BIT_CYC_FIX(BC), .HALF_CYC_M0(2)) dut_u (
    .clk     (clk),
    .reset_n (reset_n),
    .bus_req (bus_req),
    .rd_data (rd_data),
    .irq     (irq),
    .rxd_in  (rxd_in),
    .rxd_out (rxd_out),
    .rxd_oe  (rxd_oe),
    .txd_out (txd_out)
  );

  serial_node node_u (
    .clk  (clk),
    .line (rxd_in)
  );

  // ==========================================================================
  // clock and hang guard
  initial clk = 1'b0;
  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================================
  // helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o, input logic [7:0] m);
    return (((a ^ o) & m) == 8'h00) || (((~a) & (o | m)) == 8'h00);
  endfunction : hit

  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    d = rd_data;
  endtask : rd

  task automatic rx_flag(input logic exp, input string what);
    logic [7:0] c;
    rd(3'h1, c);
    check(what, {7'h00, c[0]}, {7'h00, exp});
  endtask : rx_flag

  // ==========================================================================
  // main sequence
  initial
  begin
    bus_req = '0;
    reset_n = 1'b0;
    cycles = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(3'h3, v);
    check("own_address", v, 8'h00);
    rd(3'h4, v);
    check("address_mask", v, 8'h00);
    rd(3'h7, v);
    check("unmapped", v, 8'h00);
    check("rxd_oe idle", {7'h00, rxd_oe}, 8'h00);
    check("rxd_out idle", {7'h00, rxd_out}, 8'h01);
    check("txd_out idle", {7'h00, txd_out}, 8'h01);
    rd(3'h5, v);
    wr(3'h6, 8'h01);
    for (int m = 1; m < 4; m++)
    begin
      b = $random(seed);
      wr(3'h1, {m[1:0], 6'h10});
      node_u.send(b, 1'b0, m > 1, 1'b1, BC);
      check("irq", {7'h00, irq}, 8'h01);
      rx_flag(1'b1, "rx_complete_flag");
      rd(3'h0, v);
      check("serial_buffer", v, b);
      rd(3'h5, v);
      check("irq_status", v & 8'h01, 8'h01);
      rx_flag(1'b1, "rx_complete_flag held");
    end
    check("irq cleared", {7'h00, irq}, 8'h00);
    wr(3'h1, 8'h40);
    node_u.send(8'h5a, 1'b0, 1'b0, 1'b1, BC);
    rx_flag(1'b0, "rx while disabled");
    wr(3'h6, 8'h00);
    for (int m = 1; m < 4; m++)
    begin
      b = $random(seed);
      wr(3'h2, 8'h40);
      wr(3'h1, {m[1:0], 6'h10});
      node_u.send(b, 1'b0, m > 1, 1'b0, BC);
      rd(3'h2, v);
      check("framing_error_flag", v & 8'h80, 8'h80);
      check("masked irq", {7'h00, irq}, 8'h00);
      rd(3'h5, v);
      check("irq_status fe", v & 8'h04, 8'h04);
      wr(3'h1, {m[1:0], 6'h10});
      node_u.send(b, 1'b0, m > 1, 1'b1, BC);
      rd(3'h2, v);
      check("framing_error_flag kept", v & 8'h80, 8'h80);
      rx_flag(1'b1, "rx flag at stop");
    end
    wr(3'h2, 8'h00);
    wr(3'h3, 8'hf1);
    wr(3'h4, 8'hfa);
    for (int i = 0; i < 10; i++)
    begin
      b = (i < 4) ? picks[i] : 8'($random(seed));
      wr(3'h1, 8'hb0);
      node_u.send(b, 1'b1, 1'b1, 1'b1, BC);
      rx_flag(hit(b, 8'hf1, 8'hfa), "address match");
    end
    wr(3'h1, 8'hb0);
    node_u.send(8'hf0, 1'b0, 1'b1, 1'b1, BC);
    rx_flag(1'b0, "data while filtering");
    wr(3'h1, 8'h90);
    node_u.send(8'h3c, 1'b0, 1'b1, 1'b1, BC);
    rx_flag(1'b1, "data after filter off");
    rd(3'h0, v);
    check("serial_buffer data", v, 8'h3c);
    wr(3'h1, 8'h70);
    node_u.send(8'hf0, 1'b0, 1'b0, 1'b1, BC);
    rx_flag(1'b1, "mode 1 address");
    wr(3'h1, 8'h70);
    node_u.send(8'hf0, 1'b0, 1'b0, 1'b0, BC);
    rx_flag(1'b0, "mode 1 no stop");
    wr(3'h1, 8'h70);
    node_u.send(8'h02, 1'b0, 1'b0, 1'b1, BC);
    rx_flag(1'b0, "mode 1 miss");
    // mode 0 receive starts by itself; the filter bit must not stop it
    wr(3'h1, 8'h30);
    repeat (60) @(posedge clk);
    rx_flag(1'b1, "mode 0 receive");
    rd(3'h0, v);
    check("serial_buffer mode 0", v, 8'hff);
    wr(3'h1, 8'h00);
    b = 8'($random(seed));
    wr(3'h0, b);
    repeat (3) @(negedge clk);
    check("rxd_oe", {7'h00, rxd_oe}, 8'h01);
    // each bit stands one shift clock period; look while the clock is high
    for (int k = 0; k < 8; k++)
    begin
      check("rxd_out bit", {7'h00, rxd_out}, {7'h00, b[k]});
      check("shift clock high", {7'h00, txd_out}, 8'h01);
      repeat (2) @(negedge clk);
      if (k < 7)
        check("shift clock low", {7'h00, txd_out}, 8'h00);
      repeat (2) @(negedge clk);
    end
    check("rxd_oe released", {7'h00, rxd_oe}, 8'h00);
    repeat (60) @(posedge clk);
    rd(3'h1, v);
    check("mode 0 tx done", v & 8'h02, 8'h02);
    wr(3'h1, 8'h40);
    b = $random(seed);
    f = {1'b1, b, 1'b0};
    wr(3'h0, b);
    repeat (3) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 10; i++)
    begin
      check("txd_out bit", {7'h00, txd_out}, {7'h00, f[i]});
      repeat (BC) @(negedge clk);
    end
    wr(3'h6, 8'h02);
    @(negedge clk);
    check("irq tx", {7'h00, irq}, 8'h01);
    rd(3'h5, v);
    check("irq_status tx", v & 8'h02, 8'h02);
    summarize();
  end
endmodule : uart_frame_check_addr_match_tb
